// ==== efs_far_end.sv ====
`timescale 1ns/1ps
// Far-end terminal: one frame every three cycles, words alternate
module efs_far_end (
	input  wire logic clk,       // Receive clock
	output logic      tick,      // Frame pulse
	output logic      mf_start,  // CRC-4 multiframe pulse
	output logic      fas_stb,   // Alignment word valid
	output logic [7:0] fas_byte,  // Alignment word, bit one in [7]
	output logic      nfas_stb,  // Non-alignment word valid
	output logic [7:0] nfas_byte  // Non-alignment word, bit one in [7]
);
	int unsigned fc = 0;
	logic [7:0]  last_fas = 8'h00;
	logic [7:0]  last_nfas = 8'h00;

	initial begin
		{tick, mf_start, fas_stb, nfas_stb} = 4'h0;
		fas_byte = 8'h00;
		nfas_byte = 8'h00;
	end

	task automatic frames(input int n);
		repeat (n) begin
			@(negedge clk);
			fc++;
			tick = 1'b1;
			mf_start = (fc % 16 == 0);
			if (fc % 2 == 1) begin
				fas_byte = {1'($urandom), 7'h1b};
				last_fas = fas_byte;
				fas_stb = 1'b1;
			end else begin
				nfas_byte = {1'($urandom), 1'b1, 6'($urandom)};
				last_nfas = nfas_byte;
				nfas_stb = 1'b1;
			end
			@(negedge clk);
			{tick, mf_start, fas_stb, nfas_stb} = 4'h0;
			// Released words show inverted data so a stale capture is caught
			fas_byte = ~fas_byte;
			nfas_byte = ~nfas_byte;
			@(negedge clk);
		end
	endtask
endmodule // efs_far_end

// ==== efs_frame_timer.sv ====
`timescale 1ns/1ps
// Counts frame ticks while run is high; pulses expire and restarts each period.
module efs_frame_timer #(
	parameter int W      = 12,
	parameter int PERIOD = 64
) (
	input  wire logic clk,        // Receive clock
	input  wire logic rst_b,      // Async reset, active low
	input  wire logic tick,       // One pulse per frame
	input  wire logic run,        // Timer armed
	output logic      expire      // One-cycle pulse at expiry
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         exp;
	} efs_ft_st_t;

	efs_ft_st_t st_ff;
	efs_ft_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.exp = 1'b0;
		// A dropped run clears the count so each search starts a full period
		if (!run) begin
			nxt_st.cnt = '0;
		end else if (tick) begin
			if (st_ff.cnt == W'(PERIOD - 1)) begin
				nxt_st.cnt = '0;
				nxt_st.exp = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign expire = st_ff.exp;
endmodule // efs_frame_timer

// ==== efs_pkg.sv ====
package efs_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_SYNC_STATUS = 8'h10;
	localparam logic [7:0] OFS_RX_FAS      = 8'h11;
	localparam logic [7:0] OFS_TIMER       = 8'h12;
	localparam logic [7:0] OFS_RX_NFAS     = 8'h13;
	localparam logic [7:0] RD_UNMAPPED     = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_FRAME_LOSS = 7;
	localparam int BIT_MF_LOSS    = 6;
	localparam int BIT_CRC_LOSS   = 5;
	localparam int BIT_FEB_ONE    = 4;
	localparam int BIT_FEB_TWO    = 3;
	localparam int BIT_REFRAME    = 2;
	localparam int BIT_PERSIST    = 1;
	localparam int BIT_INTERWORK  = 0;
	localparam int BIT_HALF_SEC   = 7;
	localparam int BIT_ONE_SEC    = 6;
	localparam int BIT_CRC_WIN    = 5;
	localparam int BIT_FEB_WIN    = 4;
	localparam int BIT_LONG_TOG   = 3;
	localparam int BIT_SHORT_TOG  = 2;
	localparam int BIT_ALIGN_TOG  = 1;
	localparam int BIT_TIMER_FREE = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ----------------------------------------
	// Timing, counted in received frames
	// ----------------------------------------
	localparam int FRAME_US       = 125;
	localparam int SHORT_MS       = 8;
	localparam int LONG_MS        = 400;
	localparam int ALIGN_TOG_MS   = 2;
	localparam int HALF_SEC_MS    = 500;
	localparam int FRAMES_SHORT   = SHORT_MS * 1000 / FRAME_US;
	localparam int FRAMES_LONG    = LONG_MS * 1000 / FRAME_US;
	localparam int FRAMES_ALIGN   = ALIGN_TOG_MS * 1000 / FRAME_US;
	localparam int FRAMES_HALF    = HALF_SEC_MS * 1000 / FRAME_US;
	localparam int TMR_W          = 12;
	localparam logic [6:0] PERSIST_LOAD = 7'(FRAMES_SHORT);
	localparam logic [3:0] ALIGN_LAST   = 4'(FRAMES_ALIGN - 1);

endpackage

// ==== efs_rx_status.sv ====
`timescale 1ns/1ps
module efs_rx_status #(
	parameter int FRAMES_HALF  = efs_pkg::FRAMES_HALF,
	parameter int FRAMES_LONG  = efs_pkg::FRAMES_LONG,
	parameter int FRAMES_SHORT = efs_pkg::FRAMES_SHORT
) (
	input  wire logic       CLK,             // Receive clock, 250 MHz
	input  wire logic       RST_B,           // Async reset, active low
	input  wire logic       FRAME_TICK,      // One pulse per received frame
	input  wire logic       FRAME_LOSS,      // Basic frame alignment lost
	input  wire logic       MULTIFRAME_LOSS, // Multiframe alignment lost
	input  wire logic       CHECKSUM_MF_LOSS,// CRC-4 multiframe alignment lost
	input  wire logic       CHECKSUM_INTERWORK, // Far end runs CRC-4
	input  wire logic       CHECKSUM_MF_START,  // Pulse at each CRC-4 multiframe
	input  wire logic       MF_END_STB,      // Pulse: far-end error bits valid
	input  wire logic [1:0] FAR_ERR_BITS,    // [1] first, [0] second bit
	input  wire logic       FAS_STB,         // Pulse: alignment byte valid
	input  wire logic [7:0] FAS_BYTE,        // Bit one in [7]
	input  wire logic       NFAS_STB,        // Pulse: non-alignment byte valid
	input  wire logic [7:0] NFAS_BYTE,       // Bit one in [7]
	input  wire logic [7:0] ADDR,            // Register address
	input  wire logic       RD_STB,          // Read strobe
	input  wire logic       WR_STB,          // Write strobe, ignored
	input  wire logic [7:0] WR_DATA,         // Write data, ignored
	output logic      [7:0] RD_DATA          // Read data, one cycle after RD_STB
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] fas;
		logic [7:0] nfas;
		logic       feb_one;
		logic       feb_two;
		logic       reframe;
		logic       persist;
		logic [6:0] persist_cnt;
		logic       short_tog;
		logic       long_tog;
		logic       align_tog;
		logic [3:0] align_cnt;
	} efs_st_t;

	efs_st_t st_ff;
	efs_st_t nxt_st;

	logic       search_run;
	logic       short_exp;
	logic       long_exp;
	logic       half_tog;
	logic       one_tog;
	logic       err_win;
	logic [7:0] sync_word;
	logic [7:0] timer_word;

	// ----------------------------------------
	// Alignment timers and second base
	// ----------------------------------------
	// Timers only run while framed but hunting for CRC-4 multiframe
	assign search_run = !FRAME_LOSS && CHECKSUM_MF_LOSS;

	efs_frame_timer #(.W(efs_pkg::TMR_W), .PERIOD(FRAMES_SHORT)) u_short (
		.clk    (CLK),
		.rst_b  (RST_B),
		.tick   (FRAME_TICK),
		.run    (search_run),
		.expire (short_exp)
	);

	efs_frame_timer #(.W(efs_pkg::TMR_W), .PERIOD(FRAMES_LONG)) u_long (
		.clk    (CLK),
		.rst_b  (RST_B),
		.tick   (FRAME_TICK),
		.run    (search_run),
		.expire (long_exp)
	);

	efs_second_base #(.W(efs_pkg::TMR_W), .HALF(FRAMES_HALF),
		.WIN_FRAMES(FRAMES_SHORT)) u_sec (
		.clk      (CLK),
		.rst_b    (RST_B),
		.tick     (FRAME_TICK),
		.half_tog (half_tog),
		.one_tog  (one_tog),
		.win      (err_win)
	);

	// ----------------------------------------
	// Register words
	// ----------------------------------------
	always_comb begin
		sync_word = efs_pkg::RST_BYTE;
		sync_word[efs_pkg::BIT_FRAME_LOSS] = FRAME_LOSS;
		sync_word[efs_pkg::BIT_MF_LOSS]    = MULTIFRAME_LOSS;
		sync_word[efs_pkg::BIT_CRC_LOSS]   = CHECKSUM_MF_LOSS;
		sync_word[efs_pkg::BIT_FEB_ONE]    = st_ff.feb_one;
		sync_word[efs_pkg::BIT_FEB_TWO]    = st_ff.feb_two;
		sync_word[efs_pkg::BIT_REFRAME]    = st_ff.reframe;
		sync_word[efs_pkg::BIT_PERSIST]    = st_ff.persist;
		sync_word[efs_pkg::BIT_INTERWORK]  = CHECKSUM_INTERWORK;
		timer_word = efs_pkg::RST_BYTE;
		timer_word[efs_pkg::BIT_HALF_SEC]  = half_tog;
		timer_word[efs_pkg::BIT_ONE_SEC]   = one_tog;
		timer_word[efs_pkg::BIT_CRC_WIN]   = err_win;
		timer_word[efs_pkg::BIT_FEB_WIN]   = err_win;
		timer_word[efs_pkg::BIT_LONG_TOG]  = st_ff.long_tog;
		timer_word[efs_pkg::BIT_SHORT_TOG] = st_ff.short_tog;
		timer_word[efs_pkg::BIT_ALIGN_TOG] = st_ff.align_tog;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// Captured bytes keep line order, bit one in the top bit
		if (FAS_STB) begin
			nxt_st.fas = FAS_BYTE;
		end
		if (NFAS_STB) begin
			nxt_st.nfas = NFAS_BYTE;
		end
		if (MF_END_STB) begin
			nxt_st.feb_one = FAR_ERR_BITS[1];
			nxt_st.feb_two = FAR_ERR_BITS[0];
		end
		// Set wins over clear, though both cannot meet here
		if (!CHECKSUM_MF_LOSS) begin
			nxt_st.reframe = 1'b0;
		end
		if (short_exp && CHECKSUM_MF_LOSS) begin
			nxt_st.reframe = 1'b1;
		end
		if (FRAME_LOSS) begin
			nxt_st.persist     = 1'b1;
			nxt_st.persist_cnt = 7'(FRAMES_SHORT);
		end else if (st_ff.persist && FRAME_TICK) begin
			nxt_st.persist_cnt = st_ff.persist_cnt - 7'h01;
			if (st_ff.persist_cnt == 7'h01) begin
				nxt_st.persist = 1'b0;
			end
		end
		if (short_exp) begin
			nxt_st.short_tog = !st_ff.short_tog;
		end
		if (long_exp) begin
			nxt_st.long_tog = !st_ff.long_tog;
		end
		// Aligned: follow the received multiframe; else free-run every 2 ms
		if (!CHECKSUM_MF_LOSS) begin
			nxt_st.align_cnt = 4'h0;
			if (CHECKSUM_MF_START) begin
				nxt_st.align_tog = !st_ff.align_tog;
			end
		end else if (FRAME_TICK) begin
			if (st_ff.align_cnt == efs_pkg::ALIGN_LAST) begin
				nxt_st.align_cnt = 4'h0;
				nxt_st.align_tog = !st_ff.align_tog;
			end else begin
				nxt_st.align_cnt = st_ff.align_cnt + 4'h1;
			end
		end
		// Read port only; writes never touch state
		if (RD_STB) begin
			unique case (ADDR)
				efs_pkg::OFS_SYNC_STATUS: nxt_st.rdata = sync_word;
				efs_pkg::OFS_RX_FAS:      nxt_st.rdata = st_ff.fas;
				efs_pkg::OFS_TIMER:       nxt_st.rdata = timer_word;
				efs_pkg::OFS_RX_NFAS:     nxt_st.rdata = st_ff.nfas;
				default:                  nxt_st.rdata = efs_pkg::RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign RD_DATA = st_ff.rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	a_sync_read_bits: assert property (
		RD_STB && ADDR == efs_pkg::OFS_SYNC_STATUS |=>
		RD_DATA[7:5] == {$past(FRAME_LOSS), $past(MULTIFRAME_LOSS), $past(CHECKSUM_MF_LOSS)}
		&& RD_DATA[0] == $past(CHECKSUM_INTERWORK))
		else $error("sync status read mismatch");
	a_feb_capture: assert property (
		MF_END_STB ##1 RD_STB && ADDR == efs_pkg::OFS_SYNC_STATUS && !MF_END_STB
		|=> RD_DATA[4:3] == $past(FAR_ERR_BITS, 2))
		else $error("far-end error bits not captured");
	a_feb_hold: assert property (
		!MF_END_STB |=> $stable({st_ff.feb_one, st_ff.feb_two}))
		else $error("far-end error bits moved without strobe");
	a_reframe_set: assert property (short_exp && CHECKSUM_MF_LOSS |=> st_ff.reframe)
		else $error("reframe flag not set");
	a_reframe_clear: assert property (!CHECKSUM_MF_LOSS |=> !st_ff.reframe)
		else $error("reframe flag not cleared");
	a_reframe_quiet: assert property (!st_ff.reframe && !short_exp |=> !st_ff.reframe)
		else $error("reframe flag set without expiry");
	a_persist_rise: assert property (
		FRAME_LOSS |=> st_ff.persist && st_ff.persist_cnt == 7'(FRAMES_SHORT))
		else $error("persist flag not raised");
	a_persist_fall: assert property (
		$fell(st_ff.persist) |-> !$past(FRAME_LOSS) && $past(FRAME_TICK)
		&& $past(st_ff.persist_cnt) == 7'h01)
		else $error("persist flag fell early");
	a_persist_hold: assert property (
		st_ff.persist && !FRAME_LOSS && !(FRAME_TICK && st_ff.persist_cnt == 7'h01)
		|=> st_ff.persist)
		else $error("persist flag dropped before its time");
	a_persist_quiet: assert property (!st_ff.persist && !FRAME_LOSS |=> !st_ff.persist)
		else $error("persist flag rose without loss");
	a_fas_capture: assert property (FAS_STB |=> st_ff.fas == $past(FAS_BYTE))
		else $error("alignment byte not captured");
	a_fas_hold: assert property (!FAS_STB |=> $stable(st_ff.fas))
		else $error("alignment byte moved without strobe");
	a_fas_read: assert property (
		RD_STB && ADDR == efs_pkg::OFS_RX_FAS |=> RD_DATA == $past(st_ff.fas))
		else $error("alignment byte read mismatch");
	a_nfas_capture: assert property (NFAS_STB |=> st_ff.nfas == $past(NFAS_BYTE))
		else $error("non-alignment byte not captured");
	a_nfas_hold: assert property (!NFAS_STB |=> $stable(st_ff.nfas))
		else $error("non-alignment byte moved without strobe");
	a_nfas_read: assert property (
		RD_STB && ADDR == efs_pkg::OFS_RX_NFAS |=> RD_DATA == $past(st_ff.nfas))
		else $error("non-alignment read mismatch");
	a_timer_read: assert property (
		RD_STB && ADDR == efs_pkg::OFS_TIMER |=>
		RD_DATA[7:5] == $past({half_tog, one_tog, err_win}) && RD_DATA[4] == RD_DATA[5])
		else $error("timer status read mismatch");
	a_sec_lockstep: assert property ($changed(one_tog) |-> $changed(half_tog) && !half_tog)
		else $error("second toggles out of step");
	a_one_sec_toggle: assert property ($changed(half_tog) && !half_tog |-> $changed(one_tog))
		else $error("one-second toggle missed");
	a_window_fall: assert property ($fell(err_win) |-> $changed(one_tog))
		else $error("window fell off the second boundary");
	a_long_toggle: assert property (long_exp |=> st_ff.long_tog != $past(st_ff.long_tog))
		else $error("long toggle missed");
	a_long_quiet: assert property (!long_exp |=> $stable(st_ff.long_tog))
		else $error("long toggle moved without expiry");
	a_short_toggle: assert property (short_exp |=> st_ff.short_tog != $past(st_ff.short_tog))
		else $error("short toggle missed");
	a_short_quiet: assert property (!short_exp |=> $stable(st_ff.short_tog))
		else $error("short toggle moved without expiry");
	a_align_follow: assert property (
		!CHECKSUM_MF_LOSS && !CHECKSUM_MF_START |=> $stable(st_ff.align_tog))
		else $error("align toggle moved while aligned");
	a_align_mf: assert property (
		!CHECKSUM_MF_LOSS && CHECKSUM_MF_START |=> $changed(st_ff.align_tog))
		else $error("align toggle missed the multiframe");
	a_align_free: assert property (
		CHECKSUM_MF_LOSS && FRAME_TICK && st_ff.align_cnt == efs_pkg::ALIGN_LAST
		|=> $changed(st_ff.align_tog))
		else $error("free-running align toggle missed");
	a_timer_unused: assert property (
		RD_STB && ADDR == efs_pkg::OFS_TIMER |=> RD_DATA[0] == 1'b0)
		else $error("unused timer bit not zero");
	a_write_ignored: assert property (WR_STB && !RD_STB |=> $stable(RD_DATA))
		else $error("write changed read data");
	a_read_hold: assert property (!RD_STB |=> $stable(RD_DATA))
		else $error("read data moved without a read");
	a_unmapped_read: assert property (
		RD_STB && !(ADDR inside {[efs_pkg::OFS_SYNC_STATUS:efs_pkg::OFS_RX_NFAS]})
		|=> RD_DATA == efs_pkg::RD_UNMAPPED)
		else $error("unmapped read not zero");

	c_persist_done: cover property ($fell(st_ff.persist));
	c_reframe: cover property ($rose(st_ff.reframe));
	c_timer_read: cover property (RD_STB && ADDR == efs_pkg::OFS_TIMER);
	c_align_free: cover property (CHECKSUM_MF_LOSS && $changed(st_ff.align_tog));
	c_window_fall: cover property ($fell(err_win));
endmodule // efs_rx_status

// ==== efs_second_base.sv ====
`timescale 1ns/1ps
// Free-running half/one second base with the one-second error window bit.
module efs_second_base #(
	parameter int W          = 12,
	parameter int HALF       = 4000,
	parameter int WIN_FRAMES = 64
) (
	input  wire logic clk,        // Receive clock
	input  wire logic rst_b,      // Async reset, active low
	input  wire logic tick,       // One pulse per frame
	output logic      half_tog,   // Toggles every half second
	output logic      one_tog,    // Toggles every second
	output logic      win         // High for the last window before each second
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         half;
		logic         one;
		logic         win;
	} efs_sb_st_t;

	efs_sb_st_t st_ff;
	efs_sb_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (tick) begin
			if (st_ff.cnt == W'(HALF - 1)) begin
				nxt_st.cnt  = '0;
				nxt_st.half = !st_ff.half;
				// Both toggles change on the same edge so they never skew
				if (st_ff.half) begin
					nxt_st.one = !st_ff.one;
				end
			end else begin
				nxt_st.cnt = st_ff.cnt + W'(1);
			end
			// Second boundary falls where half returns low
			nxt_st.win = st_ff.half && (nxt_st.cnt >= W'(HALF - WIN_FRAMES))
				&& (nxt_st.cnt != '0);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign half_tog = st_ff.half;
	assign one_tog  = st_ff.one;
	assign win      = st_ff.win;
endmodule // efs_second_base

// ==== tb_e1_receive_framing_status.sv ====
`timescale 1ns/1ps
module tb_e1_receive_framing_status;
	localparam int P_HALF  = 40;
	localparam int P_LONG  = 20;
	localparam int P_SHORT = 8;
	logic       clk;
	logic       rst_b;
	logic       tick;
	logic       frame_loss;
	logic       mf_loss;
	logic       crc_loss;
	logic       interwork;
	logic       mf_start;
	logic       mf_end_stb;
	logic [1:0] far_err;
	logic       fas_stb;
	logic [7:0] fas_byte;
	logic       nfas_stb;
	logic [7:0] nfas_byte;
	logic [7:0] addr;
	logic       rd_stb;
	logic       wr_stb;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic       rd_pend = 1'b0;
	logic [7:0] q_exp[$];
	logic [7:0] q_mask[$];
	logic [7:0] q_addr[$];
	int         n_mismatch = 0;
	int         comparisons = 0;
	int         t = 0;
	logic [7:0] v;
	int         cps[7] = '{7, 8, 16, 20, 41, 75, 81};

	efs_rx_status #(.FRAMES_HALF(P_HALF), .FRAMES_LONG(P_LONG), .FRAMES_SHORT(P_SHORT))
	i_efs_rx_status (
		.CLK(clk), .RST_B(rst_b), .FRAME_TICK(tick), .FRAME_LOSS(frame_loss),
		.MULTIFRAME_LOSS(mf_loss), .CHECKSUM_MF_LOSS(crc_loss),
		.CHECKSUM_INTERWORK(interwork), .CHECKSUM_MF_START(mf_start),
		.MF_END_STB(mf_end_stb), .FAR_ERR_BITS(far_err), .FAS_STB(fas_stb),
		.FAS_BYTE(fas_byte), .NFAS_STB(nfas_stb), .NFAS_BYTE(nfas_byte), .ADDR(addr),
		.RD_STB(rd_stb), .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_DATA(rd_data)
	);

	efs_far_end i_efs_far_end (
		.clk(clk), .tick(tick), .mf_start(mf_start), .fas_stb(fas_stb),
		.fas_byte(fas_byte), .nfas_stb(nfas_stb), .nfas_byte(nfas_byte)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------
	// Bus tasks and checking
	// ------------------------------
	task automatic check(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch reg_%h expected %h seen %h", a, exp, seen);
		end
	endtask

	// Reads may follow each other every cycle; idle() ends a burst
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(negedge clk);
		addr = a;
		rd_stb = 1'b1;
		q_addr.push_back(a);
		q_exp.push_back(exp & m);
		q_mask.push_back(m);
	endtask

	task automatic wr(input logic [7:0] a);
		@(negedge clk);
		addr = a;
		wr_data = 8'($urandom);
		wr_stb = 1'b1;
	endtask

	task automatic idle();
		@(negedge clk);
		rd_stb = 1'b0;
		wr_stb = 1'b0;
	endtask

	function automatic logic [7:0] timer_exp(input int n);
		logic [7:0] e;
		e = 8'h00;
		e[7] = 1'((n / P_HALF) % 2);
		e[6] = 1'((n / (2 * P_HALF)) % 2);
		e[5] = ((n % (2 * P_HALF)) >= 2 * P_HALF - P_SHORT);
		e[4] = e[5];
		e[3] = 1'((n / P_LONG) % 2);
		e[2] = 1'((n / P_SHORT) % 2);
		e[1] = 1'((n / efs_pkg::FRAMES_ALIGN) % 2);
		return e;
	endfunction

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Read data lands on the taking edge and is checked at the next falling edge
	always @(posedge clk) rd_pend <= rd_stb;

	always @(negedge clk) begin
		if (rd_pend === 1'b1 && q_exp.size() > 0)
			check(q_addr.pop_front(), rd_data & q_mask.pop_front(), q_exp.pop_front());
	end

	// ------------------------------
	// Tests
	// ------------------------------
	initial begin
		{frame_loss, mf_loss, interwork, mf_end_stb, far_err} = 6'h00;
		{addr, rd_stb, wr_stb, wr_data} = 18'h00000;
		crc_loss = 1'b1;
		rst_b = 1'b0;
		void'($urandom(29517));
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;

		for (int a = 16; a < 20; a++)
			wr(8'(a));
		idle();
		rd(8'h10, 8'h20, 8'hff);
		rd(8'h11, 8'h00, 8'hff);
		rd(8'h12, 8'h00, 8'hff);
		rd(8'h13, 8'h00, 8'hff);
		rd(8'h14, 8'h00, 8'hff);
		idle();
		$display("test reset_and_writes done");

		foreach (cps[i]) begin
			i_efs_far_end.frames(cps[i] - t);
			t = cps[i];
			rd(8'h12, timer_exp(t), 8'hff);
			rd(8'h10, {5'b00100, 1'(t >= P_SHORT), 2'b00}, 8'hff);
			rd(8'h11, i_efs_far_end.last_fas, 8'hff);
			rd(8'h13, i_efs_far_end.last_nfas, 8'hff);
			idle();
		end
		crc_loss = 1'b0;
		rd(8'h10, 8'h00, 8'hff);
		idle();
		$display("test timers_and_words done");

		frame_loss = 1'b1;
		repeat (8) begin
			@(negedge clk);
			v = 8'($urandom);
			{far_err, interwork, crc_loss, mf_loss} = v[4:0];
			mf_end_stb = 1'b1;
			rd(8'h10, {1'b1, v[0], v[1], v[4], v[3], 1'b0, 1'b1, v[2]}, 8'hff);
			mf_end_stb = 1'b0;
			idle();
		end
		$display("test live_status done");

		{frame_loss, crc_loss} = 2'b00;
		i_efs_far_end.frames(P_SHORT - 1);
		rd(8'h10, 8'h02, 8'h02);
		idle();
		i_efs_far_end.frames(1);
		rd(8'h10, 8'h00, 8'h02);
		rd(8'h12, 8'h02, 8'h02);
		idle();
		// Crosses the multiframe pulse at frame 96 while aligned
		i_efs_far_end.frames(16);
		rd(8'h12, 8'h40, 8'hff);
		idle();
		$display("test persist_and_align done");

		repeat (2) @(negedge clk);
		if (q_exp.size() != 0)
			n_mismatch++;
		conclude();
	end

	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule // tb_e1_receive_framing_status
